//--- design/dls_device.sv
// Line-side access device: register map, link bring-up, calibration,
// loopback test modes and status reporting over secondary frames.
// Assumes the host end keeps its own sequencing duties; line pins are async.
module dls_device #(
  parameter int unsigned SAMPLE_CYC   = dls_pkg::SAMPLE_CYC,
  parameter int unsigned LINK_TMO_CYC = dls_pkg::LINK_TMO_CYC
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Link to the host end
  dls_link_if.dev          lnk,
  // Line-side pins
  input  wire logic        i_line_alive,
  input  wire logic        i_line_present,
  input  wire logic [4:0]  i_line_level,
  input  wire logic [15:0] i_line_rx,
  output logic      [15:0] o_line_tx,
  output logic             o_line_pwr_en,
  output logic             o_offhook,
  output logic             o_echo_loop,
  output logic             o_cal_active
);

  typedef enum logic [2:0] {
    C_IDLE   = 3'b001,
    C_SETTLE = 3'b010,
    C_RUN    = 3'b100
  } dls_cal_t;

  typedef struct packed {
    logic [dls_pkg::NREG-1:0][7:0] regs;
    logic [15:0]                   tick_cnt;
    logic [20:0]                   est_cnt;
    logic                          link_up;
    logic                          cle;
    dls_cal_t                      cal;
    logic [10:0]                   cal_cnt;
    logic                          oh_prev;
    logic                          pres_prev;
    logic                          manual_cal_trigger_prev;
    logic                          alive_m;
    logic                          alive_s;
    logic                          pres_m;
    logic                          pres_s;
    logic [4:0]                    lvl_m;
    logic [4:0]                    lvl_s;
    logic [15:0]                   rx_m;
    logic [15:0]                   rx_s;
    logic                          frame;
    logic [15:0]                   sout;
    logic [7:0]                    rdata;
    logic                          ack;
    logic                          seen;
    logic [15:0]                   line_tx;
  } dls_dev_st_t;

  dls_dev_st_t st_q;
  dls_dev_st_t st_d;

  logic tick;
  logic line_side_powerdown;
  logic oh;
  logic autocal_disable;
  logic manual_cal_trigger;
  logic establishing;
  logic link_frame_seen;

  // Decode of control bits and link state
  assign tick         = (st_q.tick_cnt == 16'(SAMPLE_CYC - 1));
  assign line_side_powerdown          = st_q.regs[dls_pkg::A_PWR][dls_pkg::B_PDL];
  assign oh           = st_q.regs[dls_pkg::A_HOOK][dls_pkg::B_OH];
  assign autocal_disable         = st_q.regs[dls_pkg::A_CAL][dls_pkg::B_AUTOCAL_DISABLE];
  assign manual_cal_trigger         = st_q.regs[dls_pkg::A_CAL][dls_pkg::B_MANUAL_CAL_TRIGGER];
  assign establishing = !line_side_powerdown && !st_q.link_up && !st_q.cle;
  assign link_frame_seen          = st_q.link_up && (!oh || st_q.pres_s);

  // Next-state logic
  always_comb
  begin
    logic [7:0] rv;
    logic [7:0] wm;
    rv = 8'h00;
    wm = dls_pkg::reg_mask(lnk.sec_addr);
    st_d = st_q;
    st_d.ack = 1'b0;
    st_d.frame = 1'b0;

    // Two-stage synchronisers on the line pins
    st_d.alive_m = i_line_alive;
    st_d.alive_s = st_q.alive_m;
    st_d.pres_m  = i_line_present;
    st_d.pres_s  = st_q.pres_m;
    st_d.lvl_m   = i_line_level;
    st_d.lvl_s   = st_q.lvl_m;
    st_d.rx_m    = i_line_rx;
    st_d.rx_s    = st_q.rx_m;

    // Sample-period timebase
    st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;

    // Link bring-up and supervision
    if (line_side_powerdown)
    begin
      st_d.link_up = 1'b0;
      st_d.est_cnt = 21'h000000;
      st_d.cle     = 1'b0;
    end
    else if (establishing)
    begin
      st_d.est_cnt = st_q.est_cnt + 21'h000001;
      if (st_q.alive_s)
        st_d.link_up = 1'b1;
      else if (st_q.est_cnt == 21'(LINK_TMO_CYC - 1))
        st_d.cle = 1'b1;
    end
    else if (st_q.link_up && !st_q.alive_s)
    begin
      st_d.link_up = 1'b0;
      st_d.cle     = 1'b1;
    end

    // Calibration sequencer, counted in sample periods
    st_d.oh_prev   = oh;
    st_d.pres_prev = st_q.pres_s;
    st_d.manual_cal_trigger_prev = manual_cal_trigger;
    case (st_q.cal)
      C_IDLE:
        st_d.cal = C_IDLE;
      C_SETTLE:
        if (tick)
        begin
          if (st_q.cal_cnt == dls_pkg::SETTLE_FRAMES - 11'd1)
          begin
            st_d.cal     = C_RUN;
            st_d.cal_cnt = 11'h000;
          end
          else
            st_d.cal_cnt = st_q.cal_cnt + 11'h001;
        end
      C_RUN:
        if (tick)
        begin
          if (st_q.cal_cnt == dls_pkg::CAL_FRAMES - 11'd1)
            st_d.cal = C_IDLE;
          else
            st_d.cal_cnt = st_q.cal_cnt + 11'h001;
        end
      default:
        st_d.cal = C_IDLE;
    endcase
    if (!autocal_disable && oh && (!st_q.oh_prev || (st_q.pres_prev && !st_q.pres_s)))
    begin
      st_d.cal     = C_SETTLE;
      st_d.cal_cnt = 11'h000;
    end
    else if (autocal_disable && manual_cal_trigger && !st_q.manual_cal_trigger_prev)
    begin
      st_d.cal     = C_RUN;
      st_d.cal_cnt = 11'h000;
    end

    // Read view of the map; line status masked while frames unseen
    case (lnk.sec_addr)
      dls_pkg::A_HOST_MODULE_REVISION:
        rv = {4'h0, dls_pkg::REV_HOST_MOD};
      dls_pkg::A_LSTAT:
        rv = {st_q.cle, link_frame_seen, 2'b00, link_frame_seen ? st_q.lvl_s[4:1] : 4'h0};
      dls_pkg::A_LINE_CHIP_REVISION:
        rv = {1'b0, link_frame_seen & dls_pkg::LINE_VARIANT, link_frame_seen ? dls_pkg::REV_LINE : 4'h0,
              st_q.regs[dls_pkg::A_LINE_CHIP_REVISION][1:0]};
      dls_pkg::A_MEAS:
        rv = {link_frame_seen ? st_q.lvl_s : 5'h00, 3'b000};
      default:
        rv = st_q.regs[lnk.sec_addr] & wm;
    endcase

    // Frame slot: strobe, data paths and one secondary transfer
    if (tick && !establishing)
    begin
      st_d.frame = 1'b1;
      st_d.seen  = link_frame_seen;
      if (st_q.regs[dls_pkg::A_CTRL2][dls_pkg::B_AL])
        st_d.line_tx = st_q.rx_s;
      else
        st_d.line_tx = lnk.sin_data;
      if (line_side_powerdown)
        st_d.sout = dls_pkg::atten(lnk.sin_data);
      else if (!link_frame_seen || !st_q.regs[dls_pkg::A_CTRL2][dls_pkg::B_RXE])
        st_d.sout = 16'h0000;
      else if (st_q.regs[dls_pkg::A_CTRL1][dls_pkg::B_DL])
        st_d.sout = dls_pkg::atten(lnk.sin_data);
      else if (!st_q.regs[dls_pkg::A_CTRL2][dls_pkg::B_HBE])
        st_d.sout = 16'({st_q.rx_s[15], st_q.rx_s[15:1]} + {lnk.sin_data[15], lnk.sin_data[15:1]});
      else
        st_d.sout = st_q.rx_s;
      if (lnk.sec_req)
      begin
        st_d.ack = 1'b1;
        if (!lnk.sec_wr)
          st_d.rdata = rv;
        else if (lnk.sec_addr == dls_pkg::A_CTRL1 && lnk.sec_wdata[dls_pkg::B_SR])
        begin
          for (int i = 0; i < dls_pkg::NREG; i++)
            st_d.regs[i] = dls_pkg::reg_rst(5'(i));
        end
        else if (wm != 8'h00)
          st_d.regs[lnk.sec_addr] = (st_q.regs[lnk.sec_addr] & ~wm) | (lnk.sec_wdata & wm);
      end
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= '0;
      st_q.cal <= C_IDLE;
      st_q.regs[dls_pkg::A_CTRL2] <= dls_pkg::RST_CTRL2;
      st_q.regs[dls_pkg::A_PWR] <= dls_pkg::RST_PWR;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Link and line outputs
  assign lnk.frame_strobe = st_q.frame;
  assign lnk.sout_data    = st_q.sout;
  assign lnk.sec_rdata    = st_q.rdata;
  assign lnk.sec_ack      = st_q.ack;
  assign lnk.sec_seen     = st_q.seen;
  assign o_line_tx        = st_q.line_tx;
  assign o_line_pwr_en    = !line_side_powerdown;
  assign o_offhook        = oh && !line_side_powerdown;
  assign o_echo_loop      = st_q.regs[dls_pkg::A_CTRL2][dls_pkg::B_AL];
  assign o_cal_active     = (st_q.cal != C_IDLE);

endmodule

//--- design/dls_host.sv
// Host-side controller: queues register transfers into secondary frames,
// sequences manual calibration and line-side recovery, guards test modes.
// Assumes the device end answers one transfer per frame strobe.
//
// Design decision made here: the strobed register port.
module dls_host #(
  parameter int unsigned FDT_WAIT_CYC = dls_pkg::FDT_WAIT_CYC,
  parameter int unsigned PDL_HOLD_CYC = dls_pkg::PDL_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Link to the device end
  dls_link_if.host         lnk,
  // Software register port
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Sample stream
  input  wire logic [15:0] i_tx_sample,
  output logic      [15:0] o_rx_sample,
  output logic             o_rx_valid
);

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_XFER = 2'b10
  } dls_hfsm_t;

  typedef struct packed {
    dls_hfsm_t   fsm;
    logic        req;
    logic        wr;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic [1:0]  src;
    logic        sw_pend;
    logic [13:0] sw_cmd;
    logic        err;
    logic        link_fail;
    logic        seen;
    logic [7:0]  last_rd;
    logic [7:0]  sh_ctrl1;
    logic [7:0]  sh_ctrl2;
    logic [7:0]  sh_hook;
    logic [7:0]  sh_pwr;
    logic [7:0]  sh_cal;
    logic [1:0]  mc_step;
    logic [1:0]  rec_step;
    logic        fdt_wait;
    logic [20:0] wait_cnt;
    logic [10:0] ready_cnt;
    logic        test_ready;
    logic [15:0] sin;
    logic [15:0] rx;
    logic        rx_v;
    logic [15:0] rdata;
  } dls_host_st_t;

  dls_host_st_t st_q;
  dls_host_st_t st_d;

  // Next-state logic
  always_comb
  begin
    logic [4:0] ca;
    logic [7:0] cd;
    logic [1:0] modes;
    logic       bad;
    ca = i_wdata[12:8];
    cd = i_wdata[7:0];
    modes = 2'(st_q.sh_ctrl1[dls_pkg::B_DL]) + 2'(st_q.sh_ctrl2[dls_pkg::B_AL]) + 2'(!st_q.sh_ctrl2[dls_pkg::B_HBE]);
    if (ca == dls_pkg::A_CTRL1)
      modes = 2'(cd[dls_pkg::B_DL]) + 2'(st_q.sh_ctrl2[dls_pkg::B_AL]) + 2'(!st_q.sh_ctrl2[dls_pkg::B_HBE]);
    else if (ca == dls_pkg::A_CTRL2)
      modes = 2'(st_q.sh_ctrl1[dls_pkg::B_DL]) + 2'(cd[dls_pkg::B_AL]) + 2'(!cd[dls_pkg::B_HBE]);
    bad = !i_wdata[13] && (!dls_pkg::in_map(ca) || modes > 2'd1 || (modes != 2'd0 && !st_q.test_ready));
    st_d = st_q;
    st_d.rx_v = 1'b0;
    st_d.rdata = 16'h0000;

    // Transmit samples, lowered by 12 dB while the hybrid is out
    st_d.sin = st_q.sh_ctrl2[dls_pkg::B_HBE] ? i_tx_sample : {{2{i_tx_sample[15]}}, i_tx_sample[15:2]};

    // Receive samples and frame-seen flag from each frame
    if (lnk.frame_strobe)
    begin
      st_d.rx   = lnk.sout_data;
      st_d.rx_v = 1'b1;
      st_d.seen = lnk.sec_seen;
    end

    // Off-hook settle count that unlocks test modes
    if (st_q.sh_hook[dls_pkg::B_OH] && !st_q.sh_pwr[dls_pkg::B_PDL])
    begin
      if (lnk.frame_strobe && !st_q.test_ready)
      begin
        st_d.ready_cnt = st_q.ready_cnt + 11'h001;
        if (st_q.ready_cnt == dls_pkg::OFFHOOK_FRAMES - 11'd1)
          st_d.test_ready = 1'b1;
      end
    end
    else
    begin
      st_d.ready_cnt = 11'h000;
      st_d.test_ready = 1'b0;
    end

    // Frame-seen watchdog and powerdown hold timer
    if (st_q.fdt_wait || st_q.rec_step == 2'd2)
      st_d.wait_cnt = st_q.wait_cnt + 21'h000001;
    if (st_q.fdt_wait && st_q.wait_cnt == 21'(FDT_WAIT_CYC - 1))
    begin
      st_d.fdt_wait = 1'b0;
      if (!st_q.seen)
      begin
        st_d.link_fail = 1'b1;
        st_d.rec_step = 2'd1;
      end
    end
    if (st_q.rec_step == 2'd2 && st_q.wait_cnt == 21'(PDL_HOLD_CYC - 1))
      st_d.rec_step = 2'd3;

    // Software register writes; refusals and recovery set win over clear
    if (i_wr && i_addr == dls_pkg::H_STAT)
    begin
      st_d.err = st_q.err && !i_wdata[0];
      st_d.link_fail = st_d.link_fail && (!i_wdata[1] || !st_q.link_fail);
    end
    if (i_wr && i_addr == dls_pkg::H_CMD)
    begin
      if (st_q.sw_pend || bad)
        st_d.err = 1'b1;
      else
      begin
        st_d.sw_pend = 1'b1;
        st_d.sw_cmd = i_wdata[13:0];
      end
    end
    if (i_wr && i_addr == dls_pkg::H_ACT && i_wdata[0] && st_q.mc_step == 2'd0)
      st_d.mc_step = 2'd1;
    if (i_rd && i_addr == dls_pkg::H_STAT)
      st_d.rdata = {st_q.err, st_q.link_fail, st_q.seen, st_q.test_ready,
                    st_q.fsm != S_IDLE || st_q.sw_pend || st_q.mc_step != 2'd0 || st_q.rec_step != 2'd0,
                    3'b000, st_q.last_rd};

    // Transfer sequencer
    case (st_q.fsm)
      S_IDLE:
        if (st_q.rec_step == 2'd1 || st_q.rec_step == 2'd3)
        begin
          st_d.fsm = S_XFER;
          st_d.req = 1'b1;
          st_d.wr = 1'b1;
          st_d.src = 2'd2;
          st_d.addr = dls_pkg::A_PWR;
          st_d.wdata = (st_q.rec_step == 2'd1) ? (st_q.sh_pwr | 8'h10) : (st_q.sh_pwr & 8'hef);
        end
        else if (st_q.mc_step != 2'd0)
        begin
          st_d.fsm = S_XFER;
          st_d.req = 1'b1;
          st_d.wr = 1'b1;
          st_d.src = 2'd1;
          st_d.addr = dls_pkg::A_CAL;
          st_d.wdata = (st_q.sh_cal & 8'h3f) | 8'h40 | ((st_q.mc_step == 2'd2) ? 8'h80 : 8'h00);
        end
        else if (st_q.sw_pend)
        begin
          st_d.fsm = S_XFER;
          st_d.req = 1'b1;
          st_d.wr = !st_q.sw_cmd[13];
          st_d.src = 2'd0;
          st_d.addr = st_q.sw_cmd[12:8];
          st_d.wdata = st_q.sw_cmd[7:0];
          st_d.sw_pend = 1'b0;
        end
      S_XFER:
        if (lnk.sec_ack)
        begin
          st_d.fsm = S_IDLE;
          st_d.req = 1'b0;
          if (!st_q.wr)
            st_d.last_rd = lnk.sec_rdata;
          else if (st_q.addr == dls_pkg::A_CTRL1 && st_q.wdata[dls_pkg::B_SR])
          begin
            st_d.sh_ctrl1 = 8'h00;
            st_d.sh_ctrl2 = dls_pkg::RST_CTRL2;
            st_d.sh_hook = 8'h00;
            st_d.sh_pwr = dls_pkg::RST_PWR;
            st_d.sh_cal = 8'h00;
          end
          else
          begin
            case (st_q.addr)
              dls_pkg::A_CTRL1: st_d.sh_ctrl1 = st_q.wdata;
              dls_pkg::A_CTRL2: st_d.sh_ctrl2 = st_q.wdata;
              dls_pkg::A_PWR:   st_d.sh_pwr = st_q.wdata;
              dls_pkg::A_CAL:   st_d.sh_cal = st_q.wdata;
              dls_pkg::A_HOOK:
              begin
                st_d.sh_hook = st_q.wdata;
                st_d.fdt_wait = st_q.wdata[dls_pkg::B_OH] && !st_q.sh_pwr[dls_pkg::B_PDL];
                st_d.wait_cnt = 21'h000000;
              end
              default: st_d.sh_cal = st_d.sh_cal;
            endcase
          end
          if (st_q.src == 2'd1)
            st_d.mc_step = 2'(st_q.mc_step + 2'd1);
          else if (st_q.src == 2'd2)
          begin
            st_d.rec_step = (st_q.rec_step == 2'd1) ? 2'd2 : 2'd0;
            st_d.wait_cnt = 21'h000000;
          end
        end
      default:
        st_d.fsm = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= '0;
      st_q.fsm <= S_IDLE;
      st_q.sh_ctrl2 <= dls_pkg::RST_CTRL2;
      st_q.sh_pwr <= dls_pkg::RST_PWR;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Link and user outputs
  assign lnk.sin_data  = st_q.sin;
  assign lnk.sec_req   = st_q.req;
  assign lnk.sec_wr    = st_q.wr;
  assign lnk.sec_addr  = st_q.addr;
  assign lnk.sec_wdata = st_q.wdata;
  assign o_rdata       = st_q.rdata;
  assign o_rx_sample   = st_q.rx;
  assign o_rx_valid    = st_q.rx_v;

endmodule

//--- design/dls_link_if.sv
// Isolation link between the host controller and the line-side device.
// Both ends run on the same clock; the bench joins the modports.
interface dls_link_if;
  logic        frame_strobe;
  logic [15:0] sin_data;
  logic [15:0] sout_data;
  logic        sec_req;
  logic        sec_wr;
  logic [4:0]  sec_addr;
  logic [7:0]  sec_wdata;
  logic [7:0]  sec_rdata;
  logic        sec_ack;
  logic        sec_seen;

  modport dev (
    output frame_strobe, sout_data, sec_rdata, sec_ack, sec_seen,
    input  sin_data, sec_req, sec_wr, sec_addr, sec_wdata
  );

  modport host (
    input  frame_strobe, sout_data, sec_rdata, sec_ack, sec_seen,
    output sin_data, sec_req, sec_wr, sec_addr, sec_wdata
  );
endinterface

//--- design/dls_pkg.sv
// Shared constants, register map and helper functions for the line-side
// access device and its host-side controller.
// Assumes one 125 MHz clock shared by both ends of the link.
package dls_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 125_000_000;

  // Device register offsets
  localparam logic [4:0] A_CTRL1 = 5'h01;
  localparam logic [4:0] A_CTRL2 = 5'h02;
  localparam logic [4:0] A_HOOK  = 5'h05;
  localparam logic [4:0] A_PWR   = 5'h06;
  localparam logic [4:0] A_SRATE = 5'h09;
  localparam logic [4:0] A_HOST_MODULE_REVISION  = 5'h0b;
  localparam logic [4:0] A_LSTAT = 5'h0c;
  localparam logic [4:0] A_LINE_CHIP_REVISION  = 5'h0d;
  localparam logic [4:0] A_VALID = 5'h0e;
  localparam logic [4:0] A_GAIN  = 5'h0f;
  localparam logic [4:0] A_TERM  = 5'h10;
  localparam logic [4:0] A_CAL   = 5'h11;
  localparam logic [4:0] A_FEAT  = 5'h12;
  localparam logic [4:0] A_MEAS  = 5'h13;
  localparam int unsigned NREG   = 20;

  // Field positions
  localparam int unsigned B_SR   = 7;
  localparam int unsigned B_DL   = 1;
  localparam int unsigned B_AL   = 3;
  localparam int unsigned B_HBE  = 1;
  localparam int unsigned B_RXE  = 0;
  localparam int unsigned B_OH   = 0;
  localparam int unsigned B_PDL  = 4;
  localparam int unsigned B_MANUAL_CAL_TRIGGER = 7;
  localparam int unsigned B_AUTOCAL_DISABLE = 6;

  // Reset values
  localparam logic [7:0] RST_CTRL2 = 8'h03;
  localparam logic [7:0] RST_PWR   = 8'h10;

  // Identification codes, values arbitrary
  localparam logic [3:0] REV_HOST_MOD = 4'h3;
  localparam logic [3:0] REV_LINE     = 4'h5;
  localparam logic       LINE_VARIANT = 1'b0;

  // Sample-period counts
  localparam logic [10:0] CAL_FRAMES     = 11'd512;
  localparam logic [10:0] OFFHOOK_FRAMES = 11'd1548;
  localparam logic [10:0] SETTLE_FRAMES  = OFFHOOK_FRAMES - CAL_FRAMES;

  // Times and derived cycle counts
  localparam int unsigned SAMPLE_HZ    = 8000;
  localparam int unsigned SAMPLE_CYC   = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned LINK_TMO_MS  = 10;
  localparam int unsigned LINK_TMO_CYC = LINK_TMO_MS * (CLK_HZ / 1000);
  localparam int unsigned FDT_WAIT_MS  = 10;
  localparam int unsigned FDT_WAIT_CYC = FDT_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned PDL_HOLD_MS  = 1;
  localparam int unsigned PDL_HOLD_CYC = PDL_HOLD_MS * (CLK_HZ / 1000);

  // Host controller register offsets
  localparam logic [1:0] H_CMD  = 2'h0;
  localparam logic [1:0] H_STAT = 2'h1;
  localparam logic [1:0] H_ACT  = 2'h2;

  // Writable bits of each device register
  function automatic logic [7:0] reg_mask(input logic [4:0] a);
    case (a)
      A_CTRL1: reg_mask = 8'h02;
      A_CTRL2: reg_mask = 8'h0b;
      A_HOOK:  reg_mask = 8'h09;
      A_PWR:   reg_mask = 8'h7b;
      A_SRATE: reg_mask = 8'h07;
      A_LINE_CHIP_REVISION:  reg_mask = 8'h03;
      A_VALID: reg_mask = 8'h07;
      A_GAIN:  reg_mask = 8'hff;
      A_TERM:  reg_mask = 8'hff;
      A_CAL:   reg_mask = 8'hfc;
      A_FEAT:  reg_mask = 8'hff;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  // Reset value of each device register
  function automatic logic [7:0] reg_rst(input logic [4:0] a);
    case (a)
      A_CTRL2: reg_rst = RST_CTRL2;
      A_PWR:   reg_rst = RST_PWR;
      default: reg_rst = 8'h00;
    endcase
  endfunction

  // Address belongs to the defined map
  function automatic logic in_map(input logic [4:0] a);
    in_map = (reg_mask(a) != 8'h00) || (a == A_HOST_MODULE_REVISION) || (a == A_LSTAT) || (a == A_MEAS);
  endfunction

  // Filter path loss of about 0.9 dB
  function automatic logic [15:0] atten(input logic [15:0] x);
    logic signed [15:0] s;
    s = x;
    atten = 16'(s - (s >>> 3) + (s >>> 5));
  endfunction

endpackage

//--- test/dls_link_checker.sv
// Concurrent checks on the isolation link between host and device ends.
// Assumes one clock domain and an asynchronous active-high reset.
module dls_link_checker #(
  parameter int unsigned SAMPLE_CYC = 20
) (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  // Link signals
  input wire logic        frame_strobe,
  input wire logic [15:0] sout_data,
  input wire logic        sec_req,
  input wire logic        sec_wr,
  input wire logic [4:0]  sec_addr,
  input wire logic [7:0]  sec_wdata,
  input wire logic [7:0]  sec_rdata,
  input wire logic        sec_ack,
  input wire logic        sec_seen
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic [7:0] gap_q;
  // Cycles since the last frame strobe, saturating
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      gap_q <= 8'hff;
    else if (frame_strobe)
      gap_q <= 8'h00;
    else if (gap_q != 8'hff)
      gap_q <= gap_q + 8'h01;
  end
  AST_ACK_IN_FRAME: assert property (sec_ack |-> frame_strobe && sec_req) else $error("ack outside frame");
  AST_ACK_PULSE: assert property (sec_ack |=> !sec_ack) else $error("ack longer than one cycle");
  AST_STROBE_GAP: assert property (frame_strobe |-> gap_q >= SAMPLE_CYC - 1) else $error("frames too close");
  AST_SOUT_HOLD: assert property (!frame_strobe |-> $stable(sout_data)) else $error("sample moved mid-frame");
  AST_SEEN_HOLD: assert property (!frame_strobe |-> $stable(sec_seen)) else $error("seen moved mid-frame");
  AST_RDATA_HOLD: assert property (!sec_ack |-> $stable(sec_rdata)) else $error("read data moved");
  AST_REQ_HOLD: assert property (sec_req && !sec_ack |=> sec_req && $stable({sec_wr, sec_addr, sec_wdata}))
    else $error("request changed before ack");
  AST_REQ_DONE: assert property (sec_ack |=> !sec_req) else $error("request kept after ack");
  AST_ACK_WAIT: assert property ($rose(sec_req) |-> ##[0:1000] sec_ack) else $error("no ack in time");
endmodule

//--- test/testbench.sv
// Bench joining host controller and line-side device across the link.
// Assumes package, interface and both ends compile first; one 125 MHz clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned SC = 20;
  logic        i_ref_clk, i_rst, i_wr, i_rd, i_line_alive, i_line_present, o_rx_valid, o_cal_active;
  logic        o_line_pwr_en, o_offhook;
  logic [15:0] i_wdata, i_tx_sample, i_line_rx, o_rdata, o_rx_sample, o_line_tx, s;
  logic [4:0]  i_line_level;
  logic [1:0]  i_addr;
  logic [7:0]  d;
  int          mismatches, n_checks, k;
  dls_link_if dls_link_if_i ();
  dls_device #(.SAMPLE_CYC(SC), .LINK_TMO_CYC(200)) dls_device_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .lnk(dls_link_if_i), .i_line_alive(i_line_alive), .i_line_present(i_line_present), .i_line_level(i_line_level),
    .i_line_rx(i_line_rx), .o_line_tx(o_line_tx), .o_line_pwr_en(o_line_pwr_en), .o_offhook(o_offhook),
    .o_echo_loop(), .o_cal_active(o_cal_active));
  dls_host #(.FDT_WAIT_CYC(400), .PDL_HOLD_CYC(50)) dls_host_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .lnk(dls_link_if_i), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_tx_sample(i_tx_sample), .o_rx_sample(o_rx_sample), .o_rx_valid(o_rx_valid));
  dls_link_checker #(.SAMPLE_CYC(SC)) dls_link_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .frame_strobe(dls_link_if_i.frame_strobe), .sout_data(dls_link_if_i.sout_data), .sec_req(dls_link_if_i.sec_req),
    .sec_wr(dls_link_if_i.sec_wr), .sec_addr(dls_link_if_i.sec_addr), .sec_wdata(dls_link_if_i.sec_wdata),
    .sec_rdata(dls_link_if_i.sec_rdata), .sec_ack(dls_link_if_i.sec_ack), .sec_seen(dls_link_if_i.sec_seen));
  // Clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic fail(input string n);
    mismatches++;
    $display("wrong value %s expected done seen timeout", n);
    end_of_test();
  endtask
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  // Software port cycles
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // One device transfer, polled until no longer busy
  task automatic dev(input logic [15:0] c);
    wr(dls_pkg::H_CMD, c);
    for (k = 0; k < 2000; k++)
    begin
      rd(dls_pkg::H_STAT, s);
      if (s[11] === 1'b0)
        break;
    end
    if (k == 2000)
      fail("busy");
    d = s[7:0];
  endtask
  task automatic rdv(input logic [4:0] a, input logic [7:0] e, input string n);
    dev({3'b001, a, 8'h00});
    chk(n, {8'h00, e}, {8'h00, d});
  endtask
  task automatic frm(input string n, input logic [15:0] e);
    repeat (2)
    begin
      for (k = 0; k < 100; k++)
      begin
        tick();
        if (o_rx_valid === 1'b1)
          break;
      end
      if (k == 100)
        fail(n);
    end
    chk(n, e, o_rx_sample);
  endtask
  task automatic t_reset();
    rd(dls_pkg::H_STAT, s);
    chk("seen", 16'h0000, {15'h0, s[13]});
    chk("pwr en", 16'h0000, {15'h0, o_line_pwr_en});
    rdv(dls_pkg::A_CTRL2, 8'h03, "ctrl2");
    rdv(dls_pkg::A_PWR, 8'h10, "pwr");
    $display("test reset done");
  endtask
  task automatic t_loop();
    @(posedge i_ref_clk);
    i_tx_sample <= 16'h1000;
    frm("loop", 16'h0e80);
    $display("test loopback done");
  endtask
  task automatic t_cal();
    wr(dls_pkg::H_ACT, 16'h0001);
    for (k = 0; k < 4000 && o_cal_active !== 1'b1; k++)
      tick();
    if (k == 4000)
      fail("cal start");
    for (k = 0; k < 20000 && o_cal_active === 1'b1; k++)
      tick();
    chk("cal frames", 16'd512, 16'((k + SC / 2) / SC));
    $display("test calibration done");
  endtask
  task automatic t_link();
    @(posedge i_ref_clk);
    i_line_alive <= 1'b1;
    i_line_present <= 1'b1;
    i_line_level <= 5'h15;
    i_line_rx <= 16'h1234;
    dev({3'b000, dls_pkg::A_PWR, 8'h00});
    for (k = 0; k < 500; k++)
    begin
      rd(dls_pkg::H_STAT, s);
      if (s[13] === 1'b1)
        break;
    end
    chk("seen", 16'h0001, {15'h0, s[13]});
    chk("pwr en", 16'h0001, {15'h0, o_line_pwr_en});
    chk("line tx", 16'h1000, o_line_tx);
    rdv(dls_pkg::A_LSTAT, 8'h4a, "lstat");
    rdv(dls_pkg::A_MEAS, 8'ha8, "meas");
    rdv(dls_pkg::A_HOST_MODULE_REVISION, {4'h0, dls_pkg::REV_HOST_MOD}, "host_module_revision");
    rdv(dls_pkg::A_LINE_CHIP_REVISION, {1'b0, dls_pkg::LINE_VARIANT, dls_pkg::REV_LINE, 2'b00}, "line_chip_revision");
    frm("line rx", 16'h1234);
    $display("test link done");
  endtask
  task automatic t_bad();
    wr(dls_pkg::H_CMD, {3'b000, 5'h03, 8'h55});
    rd(dls_pkg::H_STAT, s);
    chk("err", 16'h0001, {15'h0, s[15]});
    wr(dls_pkg::H_STAT, 16'h0001);
    rd(dls_pkg::H_STAT, s);
    chk("err clear", 16'h0000, {15'h0, s[15]});
    $display("test refusal done");
  endtask
  task automatic t_hook();
    @(posedge i_ref_clk);
    i_line_present <= 1'b0;
    dev({3'b000, dls_pkg::A_HOOK, 8'h01});
    repeat (700) @(posedge i_ref_clk);
    rd(dls_pkg::H_STAT, s);
    chk("hook seen", 16'h0000, {15'h0, s[13]});
    chk("link fail", 16'h0001, {15'h0, s[14]});
    chk("offhook", 16'h0001, {15'h0, o_offhook});
    $display("test hook done");
  endtask
  task automatic t_srst();
    dev({3'b000, dls_pkg::A_CTRL1, 8'h80});
    rdv(dls_pkg::A_PWR, 8'h10, "srst pwr");
    rdv(dls_pkg::A_CTRL1, 8'h00, "srst ctrl1");
    $display("test soft reset done");
  endtask
  task automatic t_tmo();
    @(posedge i_ref_clk);
    i_line_alive <= 1'b0;
    dev({3'b000, dls_pkg::A_PWR, 8'h00});
    repeat (400) @(posedge i_ref_clk);
    rdv(dls_pkg::A_LSTAT, 8'h80, "timeout");
    $display("test timeout done");
  endtask
  // Main sequence
  initial
  begin
    {i_rst, i_wr, i_rd, i_line_alive, i_line_present} = 5'h10;
    {i_wdata, i_tx_sample, i_line_rx, i_line_level, i_addr} = 55'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_reset();
    t_loop();
    t_cal();
    t_link();
    t_bad();
    t_hook();
    t_srst();
    t_tmo();
    end_of_test();
  end
endmodule
